/* src/epd_pkg.sv */
// Purpose: Constants and types for the scaled encoder pulse output block.
// Assumes: 10 MHz core clock; encoder position arrives on the same clock.
// Notes: Counts and limits below are shared by the design and its bench.
//
// Operation
// - Drive differential A and B outputs with the set pulses per turn, B a quarter cycle off A.
// - Drive a differential origin output that pulses exactly once per motor turn.
// - The origin pulse is as wide as one A pulse, so it follows the set pulse count.
// - The reverse direction setting leaves the output phase relation unchanged.
// - Divide native encoder counts down to the set count, settable 16 to 1073741824, default 2048.
// - The 13-bit encoder allows up to 2048, 17-bit up to 32768, 20-bit up to 262144 pulses.
// - A set count is a multiple of 1, 2, 4, 8 or 16 in the bands ending 16384 to 262144.
// - Raise the setting alarm when the count is out of range for the encoder or off its step.
// - The speed limit is 6000 rpm up to 16384 pulses, then 3000, 1500, 750 and 375 rpm.
// - Raise the overspeed alarm when motor speed exceeds the limit for a set count that passes the setting check.
// - The quadrature pulse rate never exceeds about 1.6 million pulses per second.

package epd_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int PPR_W = 31;
  localparam int POS_W = 20;
  localparam int SPD_W = 14;
  localparam int CNT_W = 33;

  // ----------------------------------------
  // Output count settings
  // ----------------------------------------
  localparam logic [30:0] PPR_DEFAULT = 31'h0000_0800;
  localparam logic [30:0] PPR_MIN = 31'h0000_0010;
  localparam logic [30:0] PPR_MAX = 31'h4000_0000;
  localparam logic [30:0] LIM_RES13 = 31'h0000_0800;
  localparam logic [30:0] LIM_RES17 = 31'h0000_8000;
  localparam logic [30:0] LIM_RES20 = 31'h0004_0000;
  localparam logic [30:0] BAND_1 = 31'h0000_4000;
  localparam logic [30:0] BAND_2 = 31'h0000_8000;
  localparam logic [30:0] BAND_3 = 31'h0001_0000;
  localparam logic [30:0] BAND_4 = 31'h0002_0000;
  localparam logic [3:0] STEP_MASK_2 = 4'h1;
  localparam logic [3:0] STEP_MASK_4 = 4'h3;
  localparam logic [3:0] STEP_MASK_8 = 4'h7;
  localparam logic [3:0] STEP_MASK_16 = 4'hf;
  localparam logic [4:0] RES13_BITS = 5'h0d;
  localparam logic [4:0] RES17_BITS = 5'h11;
  localparam logic [4:0] RES20_BITS = 5'h14;

  // ----------------------------------------
  // Speed limits in rpm
  // ----------------------------------------
  localparam logic [13:0] SPD_LIM_1 = 14'h1770;
  localparam logic [13:0] SPD_LIM_2 = 14'h0bb8;
  localparam logic [13:0] SPD_LIM_3 = 14'h05dc;
  localparam logic [13:0] SPD_LIM_4 = 14'h02ee;
  localparam logic [13:0] SPD_LIM_5 = 14'h0177;
  localparam int HOMING_RPM = 600;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int MAX_PPS = 1_600_000;
  localparam int STATES_PER_PULSE = 4;
  localparam int STEP_RAW =
    (CLK_HZ + MAX_PPS * STATES_PER_PULSE - 1) / (MAX_PPS * STATES_PER_PULSE);
  localparam int STEP_CYC = (STEP_RAW < 1) ? 1 : STEP_RAW;
  localparam logic [3:0] STEP_LAST = 4'(STEP_CYC - 1);

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    RES_13,
    RES_17,
    RES_20
  } epd_res_type;

  typedef struct packed {
    logic [30:0] ppr;
    epd_res_type res;
    logic dir;
  } epd_cfg_type;

endpackage : epd_pkg

/* src/epd_top.sv */
// Purpose: Turns motor encoder position into scaled quadrature and origin pulses.
// Assumes: enc_pos is the position within one turn, on core_clk, from encoder logic.
// Notes: Configuration is meant to change only across a restart, as on the drive.

`timescale 1ns/1ns

module epd_top
  import epd_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Configuration
  input epd_cfg_type cfg,
  // Motor feedback
  input wire logic [POS_W-1:0] enc_pos,
  input wire logic [SPD_W-1:0] motor_speed,
  // Differential pulse pins
  output logic quad_a_out_p,
  output logic quad_a_out_n,
  output logic quad_b_out_p,
  output logic quad_b_out_n,
  output logic origin_out_p,
  output logic origin_out_n,
  // Alarms
  output logic setting_alarm,
  output logic overspeed_alarm
);

  // ----------------------------------------
  // Setting check and speed limit
  // ----------------------------------------
  logic [30:0] res_lim;
  logic [3:0] step_mask;
  logic [13:0] spd_lim;
  logic [4:0] res_bits;
  logic set_bad;

  always_comb begin
    unique case (cfg.res)
      RES_13: begin
        res_lim = LIM_RES13;
        res_bits = RES13_BITS;
      end
      RES_17: begin
        res_lim = LIM_RES17;
        res_bits = RES17_BITS;
      end
      RES_20: begin
        res_lim = LIM_RES20;
        res_bits = RES20_BITS;
      end
      default: begin
        res_lim = 31'h0;
        res_bits = RES20_BITS;
      end
    endcase
    if (cfg.ppr <= BAND_1) begin
      step_mask = 4'h0;
      spd_lim = SPD_LIM_1;
    end else if (cfg.ppr <= BAND_2) begin
      step_mask = STEP_MASK_2;
      spd_lim = SPD_LIM_2;
    end else if (cfg.ppr <= BAND_3) begin
      step_mask = STEP_MASK_4;
      spd_lim = SPD_LIM_3;
    end else if (cfg.ppr <= BAND_4) begin
      step_mask = STEP_MASK_8;
      spd_lim = SPD_LIM_4;
    end else begin
      step_mask = STEP_MASK_16;
      spd_lim = SPD_LIM_5;
    end
    // Unknown resolution code leaves res_lim zero, so it always alarms
    set_bad = (cfg.ppr < PPR_MIN) || (cfg.ppr > PPR_MAX) || (cfg.ppr > res_lim)
      || ((cfg.ppr[3:0] & step_mask) != 4'h0);
  end

  // ----------------------------------------
  // Position scaling
  // ----------------------------------------
  logic [50:0] prod;
  logic [52:0] prod4;
  logic [52:0] tgt_wide;
  logic [CNT_W-1:0] span;
  logic [CNT_W-1:0] half;

  always_comb begin
    // Resolutions are powers of two, so the divide is a shift
    prod = 51'(enc_pos) * 51'(cfg.ppr);
    prod4 = {prod, 2'b00};
    tgt_wide = prod4 >> res_bits;
    span = {cfg.ppr, 2'b00};
    half = {1'b0, cfg.ppr, 1'b0};
  end

  // ----------------------------------------
  // Target register
  // ----------------------------------------
  logic [CNT_W-1:0] tgt_q, tgt_d;

  always_comb begin
    // Registered so the wide product has a whole cycle to settle
    tgt_d = tgt_wide[CNT_W-1:0];
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tgt_q <= 33'h0;
    end else begin
      tgt_q <= tgt_d;
    end
  end

  // ----------------------------------------
  // Step enable divider
  // ----------------------------------------
  logic [3:0] div_q, div_d;
  logic step_en;

  always_comb begin
    // One state step per enable keeps the pulse rate under the ceiling
    step_en = (div_q == STEP_LAST);
    div_d = step_en ? 4'h0 : div_q + 4'h1;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_d;
    end
  end

  // ----------------------------------------
  // Alarm flags
  // ----------------------------------------
  logic set_q, set_d;
  logic ovs_q, ovs_d;

  always_comb begin
    set_d = set_bad;
    // Overspeed only means something for a count that passed the check
    ovs_d = !set_bad && (motor_speed > spd_lim);
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      set_q <= 1'b0;
      ovs_q <= 1'b0;
    end else begin
      set_q <= set_d;
      ovs_q <= ovs_d;
    end
  end

  // ----------------------------------------
  // Step chaser
  // ----------------------------------------
  logic [CNT_W-1:0] cur_q, cur_d;
  logic signed [CNT_W:0] diff;
  logic fwd;
  logic bwd;

  always_comb begin
    diff = $signed({1'b0, tgt_q}) - $signed({1'b0, cur_q});
    fwd = 1'b0;
    bwd = 1'b0;
    if (diff > 0) begin
      // Shortest way round the turn handles wrap at the origin
      fwd = (diff <= $signed({1'b0, half}));
      bwd = !fwd;
    end else if (diff < 0) begin
      bwd = (-diff <= $signed({1'b0, half}));
      fwd = !bwd;
    end
    cur_d = cur_q;
    // Outputs hold still while the setting is invalid
    if (step_en && !set_q) begin
      if (fwd) begin
        cur_d = (cur_q + 33'h1 >= span) ? 33'h0 : cur_q + 33'h1;
      end else if (bwd) begin
        cur_d = (cur_q == 33'h0) ? span - 33'h1 : cur_q - 33'h1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cur_q <= 33'h0;
    end else begin
      cur_q <= cur_d;
    end
  end

  // ----------------------------------------
  // Phase decode
  // ----------------------------------------
  logic a_q, a_d;
  logic b_q, b_d;
  logic c_q, c_d;

  always_comb begin
    // Direction setting is not used: phase form is the same both ways
    a_d = cur_q[0] ^ cur_q[1];
    b_d = cur_q[1];
    // High for the same two states as the first A high of the turn
    c_d = (cur_q == 33'h1) || (cur_q == 33'h2);
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      c_q <= 1'b0;
    end else begin
      a_q <= a_d;
      b_q <= b_d;
      c_q <= c_d;
    end
  end

  // ----------------------------------------
  // Output pins
  // ----------------------------------------
  logic set_pin_d;
  logic ovs_pin_d;

  always_comb begin
    // One more stage so every pin leaves a flop, in step with the pairs
    set_pin_d = set_q;
    ovs_pin_d = ovs_q;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      setting_alarm <= 1'b0;
      overspeed_alarm <= 1'b0;
    end else begin
      setting_alarm <= set_pin_d;
      overspeed_alarm <= ovs_pin_d;
    end
  end

  epd_diff_out #(.IDLE_LEVEL(1'b0)) i_quad_a (
    .core_clk(core_clk),
    .reset(reset),
    .level(a_q),
    .out_p(quad_a_out_p),
    .out_n(quad_a_out_n)
  );

  epd_diff_out #(.IDLE_LEVEL(1'b0)) i_quad_b (
    .core_clk(core_clk),
    .reset(reset),
    .level(b_q),
    .out_p(quad_b_out_p),
    .out_n(quad_b_out_n)
  );

  epd_diff_out #(.IDLE_LEVEL(1'b0)) i_origin (
    .core_clk(core_clk),
    .reset(reset),
    .level(c_q),
    .out_p(origin_out_p),
    .out_n(origin_out_n)
  );

endmodule : epd_top

// ----------------------------------------
// Differential output pair
// ----------------------------------------
module epd_diff_out
  import epd_pkg::*;
#(
  parameter logic IDLE_LEVEL = 1'b0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Level to show
  input wire logic level,
  // Pin pair
  output logic out_p,
  output logic out_n
);

  logic p_d;
  logic n_d;

  always_comb begin
    // Both legs from one register stage, so the pair never skews by a cycle
    p_d = level;
    n_d = !level;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      out_p <= IDLE_LEVEL;
      out_n <= !IDLE_LEVEL;
    end else begin
      out_p <= p_d;
      out_n <= n_d;
    end
  end

endmodule : epd_diff_out

/* tb/epd_properties.sv */
// Purpose: Port checks for the scaled pulse output block.
// Assumes: Sees only the epd_top ports, one clock domain.
// Notes: Bound to epd_top at the foot of this file.
`timescale 1ns/1ns
module epd_properties
  import epd_pkg::*;
(
  // Clock, reset and inputs
  input wire logic core_clk,
  input wire logic reset,
  input epd_cfg_type cfg,
  input wire logic [SPD_W-1:0] motor_speed,
  // Outputs
  input logic quad_a_out_p,
  input logic quad_a_out_n,
  input logic quad_b_out_p,
  input logic quad_b_out_n,
  input logic origin_out_p,
  input logic origin_out_n,
  input logic setting_alarm,
  input logic overspeed_alarm
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  a_pair_a: assert property (
    quad_a_out_n == !quad_a_out_p) else $error("a pins not complementary");
  a_pair_b: assert property (
    quad_b_out_n == !quad_b_out_p) else $error("b pins not complementary");
  a_pair_origin: assert property (
    origin_out_n == !origin_out_p) else $error("origin pins not complementary");
  a_one_phase_step: assert property (
    !($changed(quad_a_out_p) && $changed(quad_b_out_p))) else $error("a and b moved together");
  a_rate_hold: assert property (
    $changed({quad_a_out_p, quad_b_out_p}) |=> $stable({quad_a_out_p, quad_b_out_p}))
    else $error("state held under two cycles");
  a_origin_in_a: assert property (
    origin_out_p |-> quad_a_out_p) else $error("origin outside a high");
  a_alarm_excl: assert property (
    !(setting_alarm && overspeed_alarm)) else $error("both alarms high");
  a_low_ppr_alarm: assert property (
    (cfg.ppr < PPR_MIN) [*3] |-> setting_alarm) else $error("low count not flagged");
  a_frozen_bad: assert property (
    setting_alarm [*3] |=> $stable(quad_a_out_p)) else $error("pins moved while invalid");
  a_overspeed_def: assert property (
    (cfg.ppr == PPR_DEFAULT && cfg.res == RES_13 && motor_speed > SPD_LIM_1) [*3]
    |-> overspeed_alarm) else $error("overspeed not flagged");
endmodule : epd_properties

bind epd_top epd_properties u_props (.core_clk(core_clk), .reset(reset), .cfg(cfg),
  .motor_speed(motor_speed), .quad_a_out_p(quad_a_out_p), .quad_a_out_n(quad_a_out_n),
  .quad_b_out_p(quad_b_out_p), .quad_b_out_n(quad_b_out_n), .origin_out_p(origin_out_p),
  .origin_out_n(origin_out_n), .setting_alarm(setting_alarm),
  .overspeed_alarm(overspeed_alarm));

/* tb/epd_host_model.sv */
// Purpose: Host counter of quadrature states and origin pulses.
// Assumes: Differential pairs sampled on core_clk.
// Notes: A skipped state leaves the count short, so it shows up.
`timescale 1ns/1ns
module epd_host_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Pulse pins
  input wire logic a_p,
  input wire logic a_n,
  input wire logic b_p,
  input wire logic b_n,
  input wire logic c_p,
  input wire logic c_n,
  // Counts
  output int count,
  output int origins
);
  logic [1:0] prev;
  logic [1:0] now;
  logic c_prev;
  assign now = {b_p & ~b_n, (a_p & ~a_n) ^ (b_p & ~b_n)};
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count <= 0;
      origins <= 0;
      prev <= 2'h0;
      c_prev <= 1'b0;
    end else begin
      prev <= now;
      c_prev <= c_p & ~c_n;
      if (now - prev == 2'h1) count <= count + 1;
      if (now - prev == 2'h3) count <= count - 1;
      // Trusted only at or below homing speed, as the bench keeps it
      if (c_p & ~c_n & ~c_prev) origins <= origins + 1;
    end
  end
endmodule : epd_host_model

/* tb/testbench.sv */
// Purpose: Self-checking bench for the scaled pulse output block.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: Motion uses 13 bits and 16 pulses so a turn is short.
`timescale 1ns/1ns
module testbench
  import epd_pkg::*;
;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  epd_cfg_type cfg = '{ppr: PPR_DEFAULT, res: RES_13, dir: 1'b0};
  logic [POS_W-1:0] enc_pos = '0;
  logic [SPD_W-1:0] motor_speed = '0;
  logic a_p, a_n, b_p, b_n, c_p, c_n, set_al, spd_al;
  int count, origins, fail_count, n_compared, ecur, eorg, r, p, sp;
  logic [31:0] seed = 32'h0000_0025;
  int rr[20] = '{0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 2, 2, 2, 2, 2, 2, 2, 2, 2, 2};
  int pp[20] = '{15, 16, 2048, 2049, 16384, 16385, 16386, 25000, 25001, 32768, 32772,
    32774, 65544, 65548, 131088, 131080, 262144, 262160, 1073741824, 2048};
  always #50 core_clk = ~core_clk;
  epd_top i_dut (.core_clk(core_clk), .reset(reset), .cfg(cfg), .enc_pos(enc_pos),
    .motor_speed(motor_speed), .quad_a_out_p(a_p), .quad_a_out_n(a_n), .quad_b_out_p(b_p),
    .quad_b_out_n(b_n), .origin_out_p(c_p), .origin_out_n(c_n), .setting_alarm(set_al),
    .overspeed_alarm(spd_al));
  epd_host_model i_host (.core_clk(core_clk), .reset(reset), .a_p(a_p), .a_n(a_n),
    .b_p(b_p), .b_n(b_n), .c_p(c_p), .c_n(c_n), .count(count), .origins(origins));
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic int lim_of(input int q);
    return q <= 16384 ? 6000 : q <= 32768 ? 3000 : q <= 65536 ? 1500 : q <= 131072 ? 750 : 375;
  endfunction : lim_of
  function automatic bit bad_of(input int rs, input int q);
    int top;
    int st;
    top = rs == 0 ? 2048 : rs == 1 ? 32768 : 262144;
    st = q <= 16384 ? 1 : q <= 32768 ? 2 : q <= 65536 ? 4 : q <= 131072 ? 8 : 16;
    return q < 16 || q > top || q % st != 0;
  endfunction : bad_of
  function automatic bit in_org(input int c);
    return ((c % 64) + 64) % 64 inside {1, 2};
  endfunction : in_org
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  task automatic move(input int n, input int s);
    bit was;
    repeat (n) begin
      was = in_org(ecur);
      ecur += s;
      eorg += int'(in_org(ecur) && !was);
      enc_pos = (enc_pos + 20'(s * 128)) & 20'h01fff;
      tick(6);
    end
    tick(10);
    check("state count", 32'(count), 32'(ecur));
    check("origin count", 32'(origins), 32'(eorg));
  endtask : move
  task automatic spin(input logic d);
    reset = 1'b1;
    cfg = '{ppr: 31'h0000_0010, res: RES_13, dir: d};
    enc_pos = '0;
    motor_speed = 14'h012c;
    ecur = 0;
    eorg = 0;
    tick(3);
    reset = 1'b0;
    tick(2);
    move(130, 1);
    move(70, -1);
    // An illegal resolution code forces the alarm and a zero target; nothing may move
    cfg.res = epd_res_type'(2'h3);
    tick(30);
    check("frozen count", 32'(count), 32'(ecur));
    check("frozen alarm", 32'(set_al), 32'h1);
    cfg.res = RES_13;
    tick(10);
    check("resumed count", 32'(count), 32'(ecur));
    check("cleared alarm", 32'(set_al), 32'h0);
  endtask : spin
  // Whole run is near 3000 cycles; this allows about seven times that
  initial begin
    #2_000_000;
    fail_count++;
    print_verdict();
  end
  initial begin
    tick(1);
    check("reset pins", {24'h0, a_p, a_n, b_p, b_n, c_p, c_n, set_al, spd_al}, 32'h54);
    tick(2);
    reset = 1'b0;
    tick(2);
    for (int i = 0; i < 24; i++) begin
      r = i < 20 ? rr[i] : 2;
      p = i < 20 ? pp[i] : 16 + int'(rnd() % 262200);
      for (int k = 0; k < 3; k++) begin
        sp = k == 2 ? int'(rnd() % 16384) : lim_of(p) + k;
        cfg = '{ppr: 31'(p), res: epd_res_type'(r), dir: 1'(rnd())};
        motor_speed = 14'(sp);
        tick(4);
        check("setting", 32'(set_al), 32'(bad_of(r, p)));
        check("overspeed", 32'(spd_al), 32'(!bad_of(r, p) && sp > lim_of(p)));
      end
    end
    spin(1'b0);
    spin(1'b1);
    print_verdict();
  end
endmodule : testbench
